// [src/uart_im_pkg.sv]
// package: register map, field positions, reset values and types for the
// interrupt and modem control section of the serial port.
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package uart_im_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;

  // byte addresses
  localparam logic [7:0]  OFS_RX_TX    = 8'h00;
  localparam logic [7:0]  OFS_IER      = 8'h04;
  localparam logic [7:0]  OFS_IIR      = 8'h08;
  localparam logic [7:0]  OFS_MCR      = 8'h10;
  localparam logic [7:0]  OFS_LSR      = 8'h14;
  localparam logic [7:0]  OFS_MSR      = 8'h18;

  // interrupt enable fields
  localparam int          IER_RXDATA   = 0;
  localparam int          IER_THRE     = 1;
  localparam int          IER_LINE     = 2;
  localparam int          IER_MODEM    = 3;

  // modem control fields
  localparam int          MCR_LOOP     = 4;

  // reset values
  localparam logic [3:0]  IER_RST      = 4'h0;
  localparam logic [4:0]  MCR_RST      = 5'h00;
  localparam logic [3:0]  DELTA_RST    = 4'h0;
  localparam logic [4:0]  PIN_IDLE     = 5'h1F;

  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {
    ID_MODEM  = 2'b00,
    ID_THRE   = 2'b01,
    ID_RXDATA = 2'b10,
    ID_LINE   = 2'b11
  } irq_id_t;

  // bit order matches status bits 7..4 and change bits 3..0
  typedef struct packed {
    logic carrier;
    logic ring;
    logic set_ready;
    logic clear_send;
  } modem_bits_t;

  typedef struct packed {
    logic loop;
    logic aux2;
    logic aux1;
    logic req_send;
    logic term_ready;
  } modem_ctl_t;

endpackage

// [src/sync3.sv]
// three-stage synchroniser for asynchronous pin inputs.
// assumes one clock; output follows once stages two and three agree.
`timescale 1ns/100ps
module sync3 #(
  parameter int         W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // per bit: a level is taken only when the last two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= RESET_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign q = q_reg;
endmodule // sync3

// [src/uart_im_core.sv]
// interrupt prioritisation, modem control/status and loopback of the serial port.
// assumes receiver, transmitter and line status logic on the same clock outside;
// modem pins and serial input are asynchronous.
`timescale 1ns/100ps
// Behaviour
// - four sources ranked line, data, empty, modem
// - identification read freezes the reported interrupt
// - bit 0 high means nothing pending
// - bits 2:1 encode highest pending source
// - identification bits 7:3 read zero
// - line errors raise; line status read clears
// - data ready raises; buffer read clears
// - empty cleared by identification read reporting it, or write
// - modem input changes raise; status read clears
// - enable bits 0..3 gate each source
// - all enables clear keeps interrupt low
// - control bits 0..3 drive pins inverted
// - loopback: output mark, transmit feeds receive
// - loopback: status follows control bits
// - loopback modem interrupts from control bits
// - writing change bits raises modem interrupt
// - control bits 7:5 read zero
// - change bits for clear, ready, carrier
// - ring change only on trailing edge
// - status read clears changes; any raises
// - status bits 7:4 are inverted pins outside loopback
// - reset: enable and control zero, id none
module uart_im_core
  import uart_im_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_ready,
  input  wire logic [7:0]        line_status,
  input  wire logic              line_error_pulse,
  input  wire logic              thr_empty,
  input  wire logic              tx_shift_out,
  output logic                   rx_shift_in,
  output logic [7:0]             tx_data,
  output logic                   tx_load,
  output logic                   receive_buffer_read,
  output logic                   line_status_read,
  input  wire logic              serial_input,
  output logic                   serial_output,
  input  wire logic              clear_send_n,
  input  wire logic              set_ready_n,
  input  wire logic              ring_n,
  input  wire logic              carrier_detect_input_n,
  output logic                   term_ready_n,
  output logic                   req_send_n,
  output logic                   aux1_n,
  output logic                   aux2_n,
  output logic                   interrupt_output
);

  logic [4:0]        pins_q;
  modem_ctl_t        mcr_reg;
  logic [3:0]        ier_reg;
  modem_bits_t       modem_now;
  modem_bits_t       modem_prev_reg;
  logic              prev_valid_reg;
  logic [3:0]        delta_set;
  logic [3:0]        msr_write_set;
  logic [3:0]        msr_delta_reg;
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [7:0]        awaddr_reg;
  logic [7:0]        wbyte_reg;
  logic              wlane_reg;
  logic              wr_fire;
  logic              wr_ok;
  logic              rd_fire;
  logic              rd_ok;
  logic [7:0]        rd_byte;
  logic              rd_iir_reg;
  logic              frozen;
  logic              ls_pend_reg;
  logic              thre_pend_reg;
  logic              thre_prev_reg;
  logic              iir_read;
  logic              msr_read;
  logic              thr_write;
  logic [3:0]        en_pend;
  logic              any_en;
  irq_id_t           live_id;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [7:0]        rdata_reg;
  logic [7:0]        tx_data_reg;
  logic              tx_load_reg;
  logic              intr_reg;
  logic              serial_output_reg;

  sync3 #(
    .W         (5),
    .RESET_VAL (PIN_IDLE)
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({carrier_detect_input_n, ring_n, set_ready_n, clear_send_n, serial_input}),
    .q       (pins_q)
  );

  // modem status sources
  always_comb begin
    if (mcr_reg.loop) begin
      modem_now.clear_send = mcr_reg.req_send;
      modem_now.set_ready  = mcr_reg.term_ready;
      modem_now.ring       = mcr_reg.aux1;
      modem_now.carrier    = mcr_reg.aux2;
    end else begin
      modem_now = ~pins_q[4:1];
    end
  end

  // first cycle after reset has no valid history, so no false change
  assign delta_set[0] = prev_valid_reg & (modem_prev_reg.clear_send ^ modem_now.clear_send);
  assign delta_set[1] = prev_valid_reg & (modem_prev_reg.set_ready ^ modem_now.set_ready);
  assign delta_set[2] = prev_valid_reg & modem_prev_reg.ring & ~modem_now.ring;
  assign delta_set[3] = prev_valid_reg & (modem_prev_reg.carrier ^ modem_now.carrier);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_prev_reg <= '0;
      prev_valid_reg <= 1'b0;
    end else begin
      modem_prev_reg <= modem_now;
      prev_valid_reg <= 1'b1;
    end
  end

  // a change arriving with the clearing read is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msr_delta_reg <= DELTA_RST;
    end else begin
      msr_delta_reg <= (msr_delta_reg & ~{4{msr_read}}) | delta_set | msr_write_set;
    end
  end

  // bus write side
  assign awready = !aw_have_reg && !bvalid_reg;
  assign wready  = !w_have_reg && !bvalid_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
      end else begin
        if (awvalid && awready) begin
          aw_have_reg <= 1'b1;
          awaddr_reg  <= awaddr;
        end
        if (wvalid && wready) begin
          w_have_reg <= 1'b1;
          wbyte_reg  <= wdata[7:0];
          wlane_reg  <= wstrb[0];
        end
      end
    end
  end

  always_comb begin
    wr_ok         = 1'b1;
    thr_write     = 1'b0;
    msr_write_set = 4'h0;
    if (awaddr_reg == OFS_RX_TX) begin
      thr_write = wr_fire && wlane_reg;
    end else if (awaddr_reg == OFS_MSR) begin
      msr_write_set = (wr_fire && wlane_reg) ? wbyte_reg[3:0] : 4'h0;
    end else if (awaddr_reg != OFS_IER && awaddr_reg != OFS_MCR) begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ier_reg <= IER_RST;
      mcr_reg <= MCR_RST;
    end else if (wr_fire && wlane_reg) begin
      if (awaddr_reg == OFS_IER) begin
        ier_reg <= wbyte_reg[3:0];
      end else if (awaddr_reg == OFS_MCR) begin
        mcr_reg <= wbyte_reg[4:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_reg <= 8'h00;
      tx_load_reg <= 1'b0;
    end else begin
      tx_load_reg <= thr_write;
      if (thr_write) begin
        tx_data_reg <= wbyte_reg;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // interrupt sources and priority
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ls_pend_reg   <= 1'b0;
      thre_pend_reg <= 1'b0;
      // idle level of an empty holding register, so no false edge after reset
      thre_prev_reg <= 1'b1;
    end else begin
      ls_pend_reg   <= (ls_pend_reg & ~line_status_read) | line_error_pulse;
      thre_prev_reg <= thr_empty;
      thre_pend_reg <= (thre_pend_reg & ~(thr_write | (iir_read && live_id == ID_THRE && any_en)))
                       | (thr_empty & ~thre_prev_reg);
    end
  end

  assign en_pend[IER_RXDATA] = rx_ready & ier_reg[IER_RXDATA];
  assign en_pend[IER_THRE]   = thre_pend_reg & ier_reg[IER_THRE];
  assign en_pend[IER_LINE]   = ls_pend_reg & ier_reg[IER_LINE];
  assign en_pend[IER_MODEM]  = (|msr_delta_reg) & ier_reg[IER_MODEM];
  assign any_en              = |en_pend;

  always_comb begin
    if (en_pend[IER_LINE]) begin
      live_id = ID_LINE;
    end else if (en_pend[IER_RXDATA]) begin
      live_id = ID_RXDATA;
    end else if (en_pend[IER_THRE]) begin
      live_id = ID_THRE;
    end else begin
      live_id = ID_MODEM;
    end
  end

  // the reported source and the output hold while its read is answered
  assign frozen = rvalid_reg && rd_iir_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intr_reg <= 1'b0;
    end else if (!frozen) begin
      intr_reg <= any_en;
    end
  end

  // bus read side
  assign arready             = !rvalid_reg;
  assign rd_fire             = arvalid && arready;
  assign receive_buffer_read = rd_fire && araddr == OFS_RX_TX;
  assign line_status_read    = rd_fire && araddr == OFS_LSR;
  assign iir_read            = rd_fire && araddr == OFS_IIR;
  assign msr_read            = rd_fire && araddr == OFS_MSR;

  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    if (araddr == OFS_RX_TX) begin
      rd_byte = rx_data;
    end else if (araddr == OFS_IER) begin
      rd_byte = {4'h0, ier_reg};
    end else if (araddr == OFS_IIR) begin
      rd_byte = {5'h00, live_id, ~any_en};
    end else if (araddr == OFS_MCR) begin
      rd_byte = {3'h0, mcr_reg};
    end else if (araddr == OFS_LSR) begin
      rd_byte = line_status;
    end else if (araddr == OFS_MSR) begin
      rd_byte = {modem_now, msr_delta_reg};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 8'h00;
      rd_iir_reg <= 1'b0;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rd_byte;
      rd_iir_reg <= araddr == OFS_IIR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // loopback path; a registered mark avoids a glitch on the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_output_reg <= 1'b1;
    end else begin
      serial_output_reg <= mcr_reg.loop | tx_shift_out;
    end
  end

  assign rx_shift_in      = mcr_reg.loop ? tx_shift_out : pins_q[0];
  assign serial_output    = serial_output_reg;
  assign term_ready_n     = ~mcr_reg.term_ready;
  assign req_send_n       = ~mcr_reg.req_send;
  assign aux1_n           = ~mcr_reg.aux1;
  assign aux2_n           = ~mcr_reg.aux2;
  assign interrupt_output = intr_reg;
  assign tx_data          = tx_data_reg;
  assign tx_load          = tx_load_reg;
  assign bvalid           = bvalid_reg;
  assign bresp            = bresp_reg;
  assign rvalid           = rvalid_reg;
  assign rresp            = rresp_reg;
  assign rdata            = {24'h000000, rdata_reg};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_lsr_read_quiet;
    line_status_read && !line_error_pulse;
  endsequence

  sequence s_msr_read_quiet;
    msr_read && delta_set == 4'h0 && msr_write_set == 4'h0;
  endsequence

  property p_line_first;
    ls_pend_reg && ier_reg[IER_LINE] |-> live_id == ID_LINE;
  endproperty
  a_line_first: assert property (p_line_first) else $error("line status not top");

  property p_iir_read_value;
    iir_read |=> rdata[7:0] == {5'h00, $past(live_id), !$past(any_en)};
  endproperty
  a_iir_read_value: assert property (p_iir_read_value) else $error("bad id read");

  property p_iir_high_zero;
    rvalid && rd_iir_reg |-> rdata[7:3] == 5'h00;
  endproperty
  a_iir_high_zero: assert property (p_iir_high_zero) else $error("id high bits set");

  property p_lsr_clear;
    s_lsr_read_quiet |=> !ls_pend_reg;
  endproperty
  a_lsr_clear: assert property (p_lsr_clear) else $error("line irq not cleared");

  property p_thr_clear;
    thr_write && !(thr_empty && !thre_prev_reg) |=> !thre_pend_reg ##1 tx_data == $past(wbyte_reg, 2);
  endproperty
  a_thr_clear: assert property (p_thr_clear) else $error("empty irq not cleared");

  property p_msr_clear;
    s_msr_read_quiet |=> msr_delta_reg == 4'h0;
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("change bits not cleared");

  property p_all_disabled;
    ier_reg == 4'h0 && !frozen |=> !interrupt_output;
  endproperty
  a_all_disabled: assert property (p_all_disabled) else $error("irq with no enables");

  property p_pins_inverted;
    term_ready_n != mcr_reg.term_ready && aux2_n != mcr_reg.aux2;
  endproperty
  a_pins_inverted: assert property (p_pins_inverted) else $error("control pin polarity");

  property p_loop_mark;
    mcr_reg.loop && $past(mcr_reg.loop) |-> serial_output && rx_shift_in == tx_shift_out;
  endproperty
  a_loop_mark: assert property (p_loop_mark) else $error("loopback path wrong");

  property p_freeze;
    frozen && $past(frozen) |-> $stable(interrupt_output);
  endproperty
  a_freeze: assert property (p_freeze) else $error("interrupt moved while frozen");

  property p_ring_lead;
    prev_valid_reg && !modem_prev_reg.ring && modem_now.ring && !msr_write_set[2]
      && !msr_delta_reg[2] |=> !msr_delta_reg[2];
  endproperty
  a_ring_lead: assert property (p_ring_lead) else $error("ring leading edge flagged");

  property p_reset_values;
    @(posedge aclk) disable iff (1'b0) !aresetn |=> ier_reg == 4'h0 && mcr_reg == 5'h00;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

endmodule // uart_im_core

// [test/modem_partner.sv]
// far-side data set: drives the four active-low handshake pins on command.
// assumes the bench changes line_cmd at rising edges; slow adds seven cycles.
`timescale 1ns/100ps
module modem_partner (
  input  wire logic       aclk,
  input  wire logic [3:0] line_cmd,
  input  wire logic       slow,
  input  wire logic       serial_output,
  output logic            clear_send_n,
  output logic            set_ready_n,
  output logic            ring_n,
  output logic            carrier_detect_input_n,
  output logic            serial_input
);
  logic [3:0] pipe [8] = '{default: 4'h0};
  logic [3:0] act;

  always @(posedge aclk) begin
    pipe[0] <= line_cmd;
    for (int i = 1; i < 8; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end

  assign act = slow ? pipe[7] : pipe[0];
  assign {carrier_detect_input_n, ring_n, set_ready_n, clear_send_n} = ~act;
  // remote echo: the set loops our transmit line back, so loopback must ignore it
  assign serial_input = serial_output;
endmodule // modem_partner

// [test/uart_interrupt_modem_control_test.sv]
// self-checking bench for uart_im_core: registers, priorities, modem pins, loopback.
// assumes modem_partner on the handshake pins and a 125 MHz clock.
`timescale 1ns/100ps
module uart_interrupt_modem_control_test;
  import uart_im_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0]        wstrb = '0, line_cmd = '0;
  logic [7:0]        rx_data = 8'h3C, line_status = 8'h61;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              rx_ready = 0, line_error_pulse = 0, thr_empty = 0;
  logic              tx_shift_out = 1, slow = 0;
  logic              awready, wready, bvalid, arready, rvalid, rx_shift_in, tx_load;
  logic              receive_buffer_read, line_status_read, serial_input, serial_output;
  logic              clear_send_n, set_ready_n, ring_n, carrier_detect_input_n;
  logic              term_ready_n, req_send_n, aux1_n, aux2_n, interrupt_output;
  logic [1:0]        bresp, rresp, resp;
  logic [DATA_W-1:0] rdata, v;
  logic [7:0]        tx_data, interrupt_enable = '0, modem_control = '0;
  logic [3:0]        st = '0, delta = '0;
  logic              ls = 0, th = 0;
  logic [31:0]       lfsr = 32'hA799;
  int                mismatches = 0, cmp_count = 0;

  always #4 aclk = ~aclk;

  uart_im_core DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .rx_data, .rx_ready, .line_status, .line_error_pulse, .thr_empty, .tx_shift_out,
    .rx_shift_in, .tx_data, .tx_load, .receive_buffer_read, .line_status_read, .serial_input,
    .serial_output, .clear_send_n, .set_ready_n, .ring_n, .carrier_detect_input_n,
    .term_ready_n, .req_send_n, .aux1_n, .aux2_n, .interrupt_output);

  modem_partner far (.aclk, .line_cmd, .slow, .serial_output, .clear_send_n, .set_ready_n,
    .ring_n, .carrier_detect_input_n, .serial_input);

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] iir_exp();
    if (ls && interrupt_enable[2]) return 8'h06;
    if (rx_ready && interrupt_enable[0]) return 8'h04;
    if (th && interrupt_enable[1]) return 8'h02;
    if (delta != 4'h0 && interrupt_enable[3]) return 8'h00;
    return 8'h01;
  endfunction

  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    // one edge between transfers so a released strobe is never raised in the same step
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ah = awready;
      wh = wready;
      bh = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) begin
        bready <= 1'b0;
        case (a)
          OFS_IER: interrupt_enable = d & 8'h0F;
          OFS_MCR: modem_control = d & 8'h1F;
          OFS_RX_TX: th = 1'b0;
          OFS_MSR: delta = delta | d[3:0];
          default: ;
        endcase
        return;
      end
    end
    mismatches++;
    wrap_up();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ah, rh;
    logic [7:0] pre;
    // lets the previous read's side effects on the model settle before pre is taken
    @(posedge aclk);
    pre = iir_exp();
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ah = arready;
      rh = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) begin
        rready <= 1'b0;
        case (a)
          OFS_LSR: ls = 1'b0;
          OFS_MSR: delta = 4'h0;
          OFS_IIR: if (pre == 8'h02) th = 1'b0;
          OFS_RX_TX: rx_ready <= 1'b0;
          default: ;
        endcase
        return;
      end
    end
    mismatches++;
    wrap_up();
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask

  // pins go through a synchroniser; twenty cycles covers the slow partner too
  task automatic msettle();
    logic [3:0] n;
    repeat (20) @(posedge aclk);
    n = modem_control[4] ? {modem_control[3], modem_control[2], modem_control[0], modem_control[1]} : line_cmd;
    delta = delta | ((n ^ st) & 4'hB);
    if (st[2] && !n[2]) delta[2] = 1'b1;
    st = n;
  endtask

  task automatic irq();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(interrupt_output, iir_exp() != 8'h01);
    @(posedge aclk);
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rc(OFS_IER, 32'h0);
    rc(OFS_MCR, 32'h0);
    rc(OFS_IIR, 32'h1);
    rc(OFS_MSR, 32'h0);
    chk({term_ready_n, req_send_n, aux1_n, aux2_n, serial_output}, 5'h1F);
    rd(8'h0C, v);
    chk(v, 32'h0);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(8'h1C, 8'hFF);
    chk(resp, RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(nxt(lfsr));
      wr(OFS_IER, lfsr[7:0]);
      rc(OFS_IER, interrupt_enable);
      wr(OFS_MCR, lfsr[15:8] & 8'hEF);
      rc(OFS_MCR, modem_control);
      chk({aux2_n, aux1_n, req_send_n, term_ready_n}, modem_control[3:0] ^ 4'hF);
      line_cmd <= lfsr[19:16];
      slow     <= lfsr[20];
      msettle();
      irq();
      rc(OFS_IIR, iir_exp());
      rc(OFS_MSR, {st, delta});
      rc(OFS_MSR, {st, 4'h0});
    end
    $display("test registers and pins done");
    wr(OFS_IER, 8'h0F);
    line_error_pulse <= 1'b1;
    @(posedge aclk);
    line_error_pulse <= 1'b0;
    rx_ready  <= 1'b1;
    thr_empty <= 1'b1;
    line_cmd  <= line_cmd ^ 4'h1;
    ls = 1'b1;
    th = 1'b1;
    msettle();
    irq();
    rc(OFS_IIR, 32'h06);
    rc(OFS_LSR, line_status);
    rc(OFS_IIR, 32'h04);
    rc(OFS_RX_TX, rx_data);
    rc(OFS_IIR, 32'h02);
    rc(OFS_IIR, 32'h00);
    thr_empty <= 1'b0;
    @(posedge aclk);
    thr_empty <= 1'b1;
    th = 1'b1;
    @(posedge aclk);
    rc(OFS_IIR, 32'h02);
    thr_empty <= 1'b0;
    @(posedge aclk);
    thr_empty <= 1'b1;
    @(posedge aclk);
    wr(OFS_RX_TX, 8'hA5);
    chk(tx_data, 8'hA5);
    rc(OFS_IIR, 32'h00);
    rc(OFS_MSR, {st, delta});
    irq();
    $display("test priority done");
    wr(OFS_IER, 8'h00);
    rx_ready <= 1'b1;
    line_cmd <= 4'h4;
    msettle();
    line_cmd <= 4'h0;
    msettle();
    irq();
    rc(OFS_IIR, 32'h01);
    rc(OFS_MSR, {st, delta});
    rd(OFS_RX_TX, v);
    $display("test disabled done");
    wr(OFS_IER, 8'h08);
    tx_shift_out <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(serial_output, 1'b0);
    wr(OFS_MCR, 8'h1A);
    line_cmd <= 4'hF;
    msettle();
    chk({serial_output, rx_shift_in}, 2'b10);
    rc(OFS_MSR, {st, delta});
    wr(OFS_MCR, 8'h15);
    msettle();
    irq();
    rc(OFS_MSR, {st, delta});
    wr(OFS_MSR, 8'h0F);
    irq();
    rc(OFS_IIR, 32'h00);
    rc(OFS_MSR, {st, delta});
    irq();
    // reprogram for normal use before dropping loopback
    wr(OFS_IER, 8'h00);
    wr(OFS_MCR, 8'h00);
    msettle();
    rc(OFS_MSR, {st, delta});
    $display("test loopback done");
    wrap_up();
  end
endmodule // uart_interrupt_modem_control_test
